// File: rtl/ccr_comparator_regs.sv
// Comparator control and mode registers with edge flags and interrupt request
`timescale 1ns/1ps

module ccr_comparator_regs (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Special-function register access
  input wire ccr_pkg::ccr_sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  // Analog comparator
  input wire logic i_cmp_raw,
  output ccr_pkg::ccr_analog_cfg_t o_analog_cfg,
  // Counter array
  input wire logic i_counter_array_ovf,
  // Results
  output logic o_routed_out,
  output logic o_irq
);
  import ccr_pkg::*;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic sel(input logic [7:0] a, input logic [7:0] base);
    sel = (a == base);
  endfunction

  wire logic hit_ctl;
  wire logic hit_md;
  wire logic wr_ctl;
  wire logic wr_md;
  assign hit_ctl = sel(i_sfr.addr, CCR_ADDR_CONTROL);
  assign hit_md = sel(i_sfr.addr, CCR_ADDR_MODE);
  assign wr_ctl = i_sfr.wr && hit_ctl;
  assign wr_md = i_sfr.wr && hit_md;

  // ---------------------------------------------------------------
  // Write-data fields
  // ---------------------------------------------------------------
  // Named views of the write byte keep each register block short
  wire logic wd_on;
  wire logic wd_rise;
  wire logic wd_fall;
  wire logic [1:0] wd_pos_hys;
  wire logic [1:0] wd_neg_hys;
  wire logic wd_latch;
  wire logic wd_rise_ie;
  wire logic wd_fall_ie;
  wire logic [1:0] wd_resp;
  assign wd_on = i_sfr.wdata[CCR_CTL_ON];
  assign wd_rise = i_sfr.wdata[CCR_CTL_RISE];
  assign wd_fall = i_sfr.wdata[CCR_CTL_FALL];
  assign wd_pos_hys = i_sfr.wdata[CCR_CTL_PHYS_HI:CCR_CTL_PHYS_LO];
  assign wd_neg_hys = i_sfr.wdata[CCR_CTL_NHYS_HI:CCR_CTL_NHYS_LO];
  assign wd_latch = i_sfr.wdata[CCR_MD_LATCH];
  assign wd_rise_ie = i_sfr.wdata[CCR_MD_RISE_IE];
  assign wd_fall_ie = i_sfr.wdata[CCR_MD_FALL_IE];
  assign wd_resp = i_sfr.wdata[CCR_MD_RESP_HI:CCR_MD_RESP_LO];

  // ---------------------------------------------------------------
  // Output synchroniser and edge detect
  // ---------------------------------------------------------------
  // Raw output is asynchronous; first stage feeds only the second
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_r <= CCR_BIT_RST;
    end else begin
      sync1_r <= i_cmp_raw;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync2_r <= CCR_BIT_RST;
    end else begin
      sync2_r <= sync1_r;
    end
  end

  // Previous synced level; a high input at reset release reads as a rise
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_r <= CCR_BIT_RST;
    end else begin
      prev_r <= sync2_r;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic on_r;
  logic rise_flag_r;
  logic fall_flag_r;
  logic [1:0] pos_hys_r;
  logic [1:0] neg_hys_r;
  logic rise_flag_nxt;
  logic fall_flag_nxt;
  wire logic live_result;
  wire logic rise_evt;
  wire logic fall_evt;

  // Gated by enable so an unpowered comparator never reports high
  assign live_result = sync2_r && on_r;

  // ---------------------------------------------------------------
  // Edge events
  // ---------------------------------------------------------------
  // Edges while disabled are ignored; the analog side is unpowered then
  assign rise_evt = sync2_r && !prev_r && on_r;
  assign fall_evt = !sync2_r && prev_r && on_r;

  // Set wins over a simultaneous software clear so no edge is lost
  always_comb begin
    rise_flag_nxt = rise_flag_r;
    if (wr_ctl) begin
      rise_flag_nxt = wd_rise;
    end
    if (rise_evt) begin
      rise_flag_nxt = 1'h1;
    end
  end

  always_comb begin
    fall_flag_nxt = fall_flag_r;
    if (wr_ctl) begin
      fall_flag_nxt = wd_fall;
    end
    if (fall_evt) begin
      fall_flag_nxt = 1'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rise_flag_r <= CCR_BIT_RST;
    end else begin
      rise_flag_r <= rise_flag_nxt;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fall_flag_r <= CCR_BIT_RST;
    end else begin
      fall_flag_r <= fall_flag_nxt;
    end
  end

  // Disabling is a control write, which also loads both flags from its bits 5 and 4
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      on_r <= CCR_BIT_RST;
    end else if (wr_ctl) begin
      on_r <= wd_on;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pos_hys_r <= CCR_HYS_RST;
    end else if (wr_ctl) begin
      pos_hys_r <= wd_pos_hys;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      neg_hys_r <= CCR_HYS_RST;
    end else if (wr_ctl) begin
      neg_hys_r <= wd_neg_hys;
    end
  end

  // ---------------------------------------------------------------
  // Mode register
  // ---------------------------------------------------------------
  logic latch_r;
  logic rise_ie_r;
  logic fall_ie_r;
  logic [1:0] resp_r;
  logic latch_nxt;

  // Overflow capture beats a software write in the same cycle
  always_comb begin
    latch_nxt = latch_r;
    if (wr_md) begin
      latch_nxt = wd_latch;
    end
    if (i_counter_array_ovf) begin
      latch_nxt = live_result;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      latch_r <= CCR_BIT_RST;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rise_ie_r <= CCR_BIT_RST;
    end else if (wr_md) begin
      rise_ie_r <= wd_rise_ie;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fall_ie_r <= CCR_BIT_RST;
    end else if (wr_md) begin
      fall_ie_r <= wd_fall_ie;
    end
  end

  // Reserved bits have no storage, so they can only read zero
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      resp_r <= CCR_RESP_RST;
    end else if (wr_md) begin
      resp_r <= wd_resp;
    end
  end

  // ---------------------------------------------------------------
  // Readback
  // ---------------------------------------------------------------
  logic [7:0] ctl_view;
  logic [7:0] md_view;
  always_comb begin
    ctl_view = CCR_BYTE_ZERO;
    ctl_view[CCR_CTL_ON] = on_r;
    ctl_view[CCR_CTL_LIVE] = live_result;
    ctl_view[CCR_CTL_RISE] = rise_flag_r;
    ctl_view[CCR_CTL_FALL] = fall_flag_r;
    ctl_view[CCR_CTL_PHYS_HI:CCR_CTL_PHYS_LO] = pos_hys_r;
    ctl_view[CCR_CTL_NHYS_HI:CCR_CTL_NHYS_LO] = neg_hys_r;
    md_view = CCR_BYTE_ZERO;
    md_view[CCR_MD_LATCH] = latch_r;
    md_view[CCR_MD_RISE_IE] = rise_ie_r;
    md_view[CCR_MD_FALL_IE] = fall_ie_r;
    md_view[CCR_MD_RESP_HI:CCR_MD_RESP_LO] = resp_r;
  end

  wire logic [7:0] rdata_sel;
  assign rdata_sel = hit_ctl ? ctl_view : (hit_md ? md_view : CCR_BYTE_ZERO);

  // Registered read data: valid the cycle after the read strobe
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sfr_rdata <= CCR_BYTE_ZERO;
    end else if (i_sfr.rd) begin
      o_sfr_rdata <= rdata_sel;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt request
  // ---------------------------------------------------------------
  // Level request: drops only when software clears a flag or its enable
  wire logic rise_req;
  wire logic fall_req;
  assign rise_req = rise_flag_r && rise_ie_r;
  assign fall_req = fall_flag_r && fall_ie_r;

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_sfr_hit = hit_ctl || hit_md;
  assign o_routed_out = live_result;
  assign o_irq = rise_req || fall_req;
  assign o_analog_cfg.on = on_r;
  assign o_analog_cfg.pos_hys = pos_hys_r;
  assign o_analog_cfg.neg_hys = neg_hys_r;
  assign o_analog_cfg.resp_mode = resp_r;

endmodule // ccr_comparator_regs

// File: rtl/ccr_pkg.sv
// Package: comparator control register constants and types
package ccr_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] CCR_ADDR_CONTROL = 8'h9B;
  localparam logic [7:0] CCR_ADDR_MODE = 8'h9D;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CCR_CTL_ON = 7;
  localparam int CCR_CTL_LIVE = 6;
  localparam int CCR_CTL_RISE = 5;
  localparam int CCR_CTL_FALL = 4;
  localparam int CCR_CTL_PHYS_HI = 3;
  localparam int CCR_CTL_PHYS_LO = 2;
  localparam int CCR_CTL_NHYS_HI = 1;
  localparam int CCR_CTL_NHYS_LO = 0;

  // ---------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------
  localparam int CCR_MD_LATCH = 7;
  localparam int CCR_MD_RISE_IE = 5;
  localparam int CCR_MD_FALL_IE = 4;
  localparam int CCR_MD_RESP_HI = 1;
  localparam int CCR_MD_RESP_LO = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] CCR_HYS_RST = 2'h0;
  localparam logic [1:0] CCR_RESP_RST = 2'h2;
  localparam logic CCR_BIT_RST = 1'h0;
  localparam logic [7:0] CCR_BYTE_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  // Special-function register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ccr_sfr_req_t;

  // Settings steering the analog comparator
  typedef struct packed {
    logic on;
    logic [1:0] pos_hys;
    logic [1:0] neg_hys;
    logic [1:0] resp_mode;
  } ccr_analog_cfg_t;

endpackage

// File: tb/ccr_comparator_regs_assertions.sv
// Port-level checks on the comparator register block
`timescale 1ns/1ps
module ccr_regs_chk (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Register access
  input wire ccr_pkg::ccr_sfr_req_t i_sfr,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_hit,
  // Comparator side
  input wire logic i_cmp_raw,
  input wire ccr_pkg::ccr_analog_cfg_t o_analog_cfg,
  input wire logic i_counter_array_ovf,
  input wire logic o_routed_out,
  input wire logic o_irq
);
  import ccr_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  wire wc = i_sfr.wr && i_sfr.addr == CCR_ADDR_CONTROL;
  wire wm = i_sfr.wr && i_sfr.addr == CCR_ADDR_MODE;
  wire rc = i_sfr.rd && i_sfr.addr == CCR_ADDR_CONTROL;
  a_hit_decode: assert property (o_sfr_hit == (i_sfr.addr == CCR_ADDR_CONTROL ||
    i_sfr.addr == CCR_ADDR_MODE)) else $error("bad hit decode");
  a_off_low: assert property (!o_analog_cfg.on |-> !o_routed_out)
    else $error("output high while off");
  a_ctl_write: assert property (wc |=> {o_analog_cfg.on, o_analog_cfg.pos_hys,
    o_analog_cfg.neg_hys} == {$past(i_sfr.wdata[7]), $past(i_sfr.wdata[3:0])})
    else $error("control write lost");
  a_mode_write: assert property (wm |=> o_analog_cfg.resp_mode == $past(i_sfr.wdata[1:0]))
    else $error("mode write lost");
  a_unmapped_zero: assert property (i_sfr.rd && !o_sfr_hit |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (i_sfr.rd && i_sfr.addr == CCR_ADDR_MODE |=>
    o_sfr_rdata[6] == 1'b0 && o_sfr_rdata[3:2] == 2'h0) else $error("reserved bits set");
  a_live_read: assert property (rc |=> o_sfr_rdata[6] == $past(o_routed_out))
    else $error("live bit wrong");
  a_sync_delay: assert property ($rose(o_routed_out) |-> $past(i_cmp_raw, 2))
    else $error("output rose too early");
  a_irq_mask: assert property (wm && i_sfr.wdata[5:4] == 2'h0 |=> !o_irq)
    else $error("masked request high");
endmodule // ccr_regs_chk
bind ccr_comparator_regs ccr_regs_chk u_chk (.i_ref_clk, .i_nrst, .i_sfr, .o_sfr_rdata,
  .o_sfr_hit, .i_cmp_raw, .o_analog_cfg, .i_counter_array_ovf, .o_routed_out, .o_irq);

// File: tb/test_ccr_comparator_regs.sv
// Directed register and edge-flag tests for the comparator register block
`timescale 1ns/1ps
module test_ccr_comparator_regs;
  import ccr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  ccr_sfr_req_t sfr = '0;
  logic raw = 1'b0;
  logic ovf = 1'b0;
  logic [7:0] rdata;
  logic routed;
  logic irq;
  ccr_analog_cfg_t cfg;
  int failures = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  ccr_comparator_regs uut (.i_ref_clk(clk), .i_nrst(nrst), .i_sfr(sfr), .o_sfr_rdata(rdata),
    .o_sfr_hit(), .i_cmp_raw(raw), .o_analog_cfg(cfg), .i_counter_array_ovf(ovf),
    .o_routed_out(routed), .o_irq(irq));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Request is held over exactly one taking edge, then dropped
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk) sfr <= {a, w, !w, d};
    @(posedge clk) sfr <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    chk(rdata, e);
  endtask
  // Raw level held five cycles, past the two-flop synchroniser
  task automatic cmp(input logic v);
    @(posedge clk) raw <= v;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic pulse;
    @(posedge clk) ovf <= 1'b1;
    @(posedge clk) ovf <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #5000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk(cfg, 8'h02);
    rd(CCR_ADDR_CONTROL, 8'h00);
    rd(CCR_ADDR_MODE, 8'h02);
    rd(8'h9C, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      xfer(CCR_ADDR_CONTROL, 1'b1, {4'h4, i[1:0], ~i[1:0]});
      rd(CCR_ADDR_CONTROL, {4'h0, i[1:0], ~i[1:0]});
      xfer(CCR_ADDR_MODE, 1'b1, {6'h0C, i[1:0]});
      rd(CCR_ADDR_MODE, {6'h0C, i[1:0]});
      chk(cfg, {1'b0, i[1:0], ~i[1:0], i[1:0]});
    end
    $display("field test done");
    xfer(CCR_ADDR_CONTROL, 1'b1, 8'h80);
    xfer(CCR_ADDR_CONTROL, 1'b1, 8'h80);
    xfer(CCR_ADDR_MODE, 1'b1, 8'h30);
    cmp(1'b1);
    chk(irq, 8'h01);
    rd(CCR_ADDR_CONTROL, 8'hE0);
    cmp(1'b0);
    rd(CCR_ADDR_CONTROL, 8'hB0);
    xfer(CCR_ADDR_CONTROL, 1'b1, 8'h80);
    rd(CCR_ADDR_CONTROL, 8'h80);
    chk(irq, 8'h00);
    xfer(CCR_ADDR_MODE, 1'b1, 8'h10);
    cmp(1'b1);
    chk(irq, 8'h00);
    cmp(1'b0);
    chk(irq, 8'h01);
    $display("edge test done");
    cmp(1'b1);
    pulse();
    rd(CCR_ADDR_MODE, 8'h90);
    cmp(1'b0);
    pulse();
    rd(CCR_ADDR_MODE, 8'h10);
    $display("overflow test done");
    xfer(CCR_ADDR_CONTROL, 1'b1, 8'h00);
    cmp(1'b1);
    chk(routed, 8'h00);
    rd(CCR_ADDR_CONTROL, 8'h00);
    $display("disable test done");
    complete_run();
  end
endmodule // test_ccr_comparator_regs
